// *** index_gating_and_edge_spacing.sv ***
// Purpose: index output gating and minimum edge spacing of the incremental outputs
// Assumes: converter steps, phase zero and index channel samples are synchronous to i_clk
// Notes: outputs registered except alarm out (tied low) and A, B, index (XORed with inversion bits after the registers); gap timer: trimmed oscillator counter
`timescale 1ns/1ps
module index_gating_and_edge_spacing
  import gap_pkg::*;
#(
  parameter int IN_W = 8
) (
  // clock, enable and reset
  input wire logic i_clk,
  input wire logic i_clk_en,
  input wire logic i_reset,
  // register port
  input wire logic i_reg_write,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // converter side
  input wire logic [IN_W-1:0] i_index_pos,
  input wire logic [IN_W-1:0] i_index_neg,
  input wire logic i_step,
  input wire logic i_step_down,
  input wire logic i_phase_zero,
  input wire logic [POS_W-1:0] i_interp_factor,
  input wire logic i_counter_mode,
  // alarm settings and request
  input wire logic [9:0] i_alarm_mask,
  input wire logic [2:0] i_alarm_hold_time,
  input wire logic i_alarm_request,
  // line driver outputs, index 0 = A, 1 = B, 2 = index
  output logic o_channel_a_out,
  output logic o_channel_b_out,
  output logic o_index_out,
  output logic [2:0] o_drive_high_en,
  output logic [2:0] o_drive_low_en,
  // open-drain alarm pin
  output logic o_alarm_out,
  output logic o_alarm_oe
);

  // configuration registers
  logic [7:0] zero_sync_config, output_logic_config, zero_position_mask;
  logic [7:0] transition_gap, driver_config, oscillator_trim;
  // converter tracking and emitter state
  logic raw_index, zero_out, alarm_oe, out_a, out_b, out_z;
  logic [1:0] quarter, emit_q;
  logic [POS_W-1:0] cycle_index;
  logic [2:0] high_en, low_en;
  logic [7:0] rdata;
  edge_state_type state;
  // next values
  logic [7:0] next_zero_sync, next_out_logic, next_zero_pos, next_gap, next_driver, next_trim;
  logic next_raw_index, next_zero_out, next_alarm_oe, next_a, next_b, next_z;
  logic [1:0] next_quarter, next_emit_q, ab;
  logic [POS_W-1:0] next_cycle_index, pos_target;
  logic [2:0] next_high_en, next_low_en, lvl;
  logic [7:0] next_rdata;
  edge_state_type next_state;
  // derived
  logic zero_internal, ab_gate, pos_match, zero_sync_enable, step_up;
  logic [3:0] transition_gap_select;
  logic [1:0] drive_mode_select;
  logic [GAP_W-1:0] gap_now;
  gap_timer_if tif ();

  ////////////////////////////////////////////////////////////////////////////////
  // register writes and registered read data
  always_comb begin
    next_zero_sync = zero_sync_config;
    next_out_logic = output_logic_config;
    next_zero_pos = zero_position_mask;
    next_gap = transition_gap;
    next_driver = driver_config;
    next_trim = oscillator_trim;
    if (i_reg_write) begin
      case (i_reg_addr)
        ADDR_ZERO_SYNC: next_zero_sync = i_reg_wdata;
        ADDR_OUT_LOGIC: next_out_logic = i_reg_wdata;
        ADDR_ZERO_POS: next_zero_pos = i_reg_wdata;
        ADDR_GAP: next_gap = i_reg_wdata;
        ADDR_DRIVER: next_driver = i_reg_wdata;
        ADDR_TRIM: next_trim = i_reg_wdata;
        default: ;
      endcase
    end
    case (i_reg_addr)
      ADDR_ZERO_SYNC: next_rdata = zero_sync_config;
      ADDR_OUT_LOGIC: next_rdata = output_logic_config;
      ADDR_ZERO_POS: next_rdata = zero_position_mask;
      ADDR_GAP: next_rdata = transition_gap;
      ADDR_DRIVER: next_rdata = driver_config;
      ADDR_TRIM: next_rdata = oscillator_trim;
      ADDR_STATUS: next_rdata = {raw_index, zero_internal, zero_out, 3'h0, emit_q};
      default: next_rdata = 8'h00;
    endcase
  end

  // setting fields
  assign zero_sync_enable = zero_sync_config[ZSYNC_BIT];
  assign transition_gap_select = transition_gap[GAP_MSB:GAP_LSB];
  assign drive_mode_select = driver_config[DRV_MSB:0];
  // gap or low pulse length scaled by the trim
  assign gap_now = gap_cycles(transition_gap_select, oscillator_trim[TRIM_MSB:0],
                              i_counter_mode);

  ////////////////////////////////////////////////////////////////////////////////
  // converter tracking: raw index compare, quarter state and cycle index
  always_comb begin
    next_raw_index = (i_index_pos > i_index_neg);
    step_up = !i_step_down;
    next_quarter = quarter;
    next_cycle_index = cycle_index;
    if (i_phase_zero) begin
      next_quarter = '0;
      next_cycle_index = '0;
    end else if (i_step) begin
      next_quarter = step_up ? quarter + 1'b1 : quarter - 1'b1;
      if (step_up && quarter == 2'h3) begin
        next_cycle_index = (cycle_index >= i_interp_factor - 1'b1) ? '0 : cycle_index + 1'b1;
      end else if (!step_up && quarter == 2'h0) begin
        next_cycle_index = (cycle_index == '0) ? i_interp_factor - 1'b1 : cycle_index - 1'b1;
      end
    end
  end

  // zero signal gating
  always_comb begin
    ab_gate = output_logic_config[2'h3 - quarter];
    pos_target = (i_interp_factor >= BIG_FACTOR) ?
      (POS_W'(zero_position_mask[ZPOS_MSB:0]) << POS_SCALE_SHIFT) :
      POS_W'(zero_position_mask[ZPOS_MSB:0]);
    pos_match = !zero_position_mask[ZPOS_EN_BIT] || (cycle_index == pos_target);
    zero_internal = raw_index && ab_gate && pos_match;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // edge emitter: one pending step at a time, spaced by the gap timer
  always_comb begin
    next_state = state;
    next_emit_q = emit_q;
    next_a = out_a;
    next_b = out_b;
    ab = 2'h0;
    next_zero_out = zero_sync_enable ? zero_out : zero_internal;
    tif.load = 1'b0;
    tif.load_value = gap_now;
    case (state)
      st_idle: begin
        if (tif.done && emit_q != quarter) begin
          next_emit_q = (quarter - emit_q == 2'h3) ? emit_q - 1'b1 : emit_q + 1'b1;
          tif.load = 1'b1;
          if (zero_sync_enable) begin
            next_zero_out = zero_internal;
          end
          if (i_counter_mode) begin
            next_a = (quarter - emit_q != 2'h3); // direction level
            next_b = 1'b0;
            next_state = st_low;
          end else begin
            ab = ab_of(next_emit_q);
            next_a = output_logic_config[SWAP_BIT] ? ab[0] : ab[1];
            next_b = output_logic_config[SWAP_BIT] ? ab[1] : ab[0];
            next_state = st_wait;
          end
        end
      end
      st_low: begin
        if (tif.done) begin
          next_b = 1'b1;
          tif.load = 1'b1;
          next_state = st_wait;
        end
      end
      st_wait: begin
        if (tif.done) begin
          next_state = st_idle;
        end
      end
      default: next_state = st_idle;
    endcase
  end

  // output levels, drive enables and alarm pin
  always_comb begin
    next_z = next_zero_out;
    lvl = {next_z ^ output_logic_config[INV_Z_BIT], next_b ^ output_logic_config[INV_B_BIT],
           next_a ^ output_logic_config[INV_A_BIT]};
    case (drive_mode_select)
      DRV_PUSH_PULL: begin
        next_high_en = lvl;
        next_low_en = ~lvl;
      end
      DRV_HIGH_SIDE: begin
        next_high_en = lvl;
        next_low_en = 3'h0;
      end
      DRV_LOW_SIDE: begin
        next_high_en = 3'h0;
        next_low_en = ~lvl;
      end
      default: begin
        next_high_en = 3'h0;
        next_low_en = 3'h0;
      end
    endcase
    if (i_alarm_mask == ALARM_ROUTE_MASK && i_alarm_hold_time == ALARM_ROUTE_HOLD) begin
      next_alarm_oe = !raw_index;
    end else begin
      next_alarm_oe = i_alarm_request;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      zero_sync_config <= RST_ZERO_SYNC;
      output_logic_config <= RST_OUT_LOGIC;
      zero_position_mask <= RST_ZERO_POS;
      transition_gap <= RST_GAP;
      driver_config <= RST_DRIVER;
      oscillator_trim <= RST_TRIM;
      rdata <= 8'h00;
      raw_index <= 1'b0;
      quarter <= 2'h0;
      cycle_index <= '0;
      state <= st_idle;
      emit_q <= 2'h0;
      out_a <= 1'b1;
      out_b <= 1'b1;
      out_z <= 1'b0;
      zero_out <= 1'b0;
      high_en <= 3'h0;
      low_en <= 3'h0;
      alarm_oe <= 1'b0;
    end else if (i_clk_en) begin
      zero_sync_config <= next_zero_sync;
      output_logic_config <= next_out_logic;
      zero_position_mask <= next_zero_pos;
      transition_gap <= next_gap;
      driver_config <= next_driver;
      oscillator_trim <= next_trim;
      rdata <= next_rdata;
      raw_index <= next_raw_index;
      quarter <= next_quarter;
      cycle_index <= next_cycle_index;
      state <= next_state;
      emit_q <= next_emit_q;
      out_a <= next_a;
      out_b <= next_b;
      out_z <= next_z;
      zero_out <= next_zero_out;
      high_en <= next_high_en;
      low_en <= next_low_en;
      alarm_oe <= next_alarm_oe;
    end
  end

  // gap timer
  gap_timer u_gap_timer (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .tif(tif.timer)
  );

  // outputs
  assign o_reg_rdata = rdata;
  assign o_channel_a_out = out_a ^ output_logic_config[INV_A_BIT];
  assign o_channel_b_out = out_b ^ output_logic_config[INV_B_BIT];
  assign o_index_out = out_z ^ output_logic_config[INV_Z_BIT];
  assign o_drive_high_en = high_en;
  assign o_drive_low_en = low_en;
  assign o_alarm_out = 1'b0;
  assign o_alarm_oe = alarm_oe;

  ////////////////////////////////////////////////////////////////////////////////
  // checks: cycles since the last emitted step, saturated out of reset
  // so that the first step after reset is not held against a gap
  logic [GAP_W-1:0] edge_age;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      edge_age <= '1;
    end else if (i_clk_en) begin
      edge_age <= (next_emit_q != emit_q) ? '0 : (&edge_age ? edge_age : edge_age + 1'b1);
    end
  end

  sequence seq_count_low_start;
    i_counter_mode && $fell(out_b);
  endsequence

  AST_ALARM_RAW: assert property (@(posedge i_clk) disable iff (i_reset || !i_clk_en)
    (i_alarm_mask == ALARM_ROUTE_MASK && i_alarm_hold_time == ALARM_ROUTE_HOLD)
    |=> (o_alarm_oe == !$past(raw_index)))
    else $error("alarm pin does not show the raw index enable");
  AST_POS_BLANK: assert property (@(posedge i_clk) disable iff (i_reset)
    (zero_position_mask[ZPOS_EN_BIT] && cycle_index != pos_target) |-> !zero_internal)
    else $error("index not blanked off the selected cycle");
  AST_ZERO_AND: assert property (@(posedge i_clk) disable iff (i_reset)
    zero_internal |-> (raw_index && ab_gate))
    else $error("zero signal set without raw enable and state gate");
  AST_SYNC_ALIGN: assert property (@(posedge i_clk) disable iff (i_reset || !i_clk_en)
    (zero_sync_enable && $past(zero_sync_enable) && $changed(zero_out)) |-> $changed(emit_q))
    else $error("synchronised index changed off an A/B step");
  AST_DRIVE_OFF: assert property (@(posedge i_clk) disable iff (i_reset || !i_clk_en)
    (drive_mode_select == 2'h3) |=> (o_drive_high_en == 3'h0 && o_drive_low_en == 3'h0))
    else $error("forbidden drive mode still drives");
  AST_QUAD_GAP: assert property (@(posedge i_clk) disable iff (i_reset || !i_clk_en)
    (!i_counter_mode && $changed(emit_q)) |-> ($past(edge_age) >= gap_now))
    else $error("quadrature edges closer than the gap");
  AST_COUNT_LOW: assert property (@(posedge i_clk) disable iff (i_reset || !i_clk_en)
    seq_count_low_start |-> (!out_b) [*8])
    else $error("count clock low pulse too short");
  AST_CYCLE_RANGE: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_interp_factor != '0 && !$changed(i_interp_factor)) |-> (cycle_index < i_interp_factor))
    else $error("cycle index beyond the interpolation factor");
  AST_STEP_ORDER: assert property (@(posedge i_clk) disable iff (i_reset || !i_clk_en)
    $changed(emit_q) |-> (emit_q - $past(emit_q) == 2'h1 || $past(emit_q) - emit_q == 2'h1))
    else $error("emitted A/B state skipped a step");

endmodule

// *** gap_pkg.sv ***
// Purpose: shared constants, types and helpers for the index gating and edge spacing block
// Assumes: 200 MHz system clock, 8-bit configuration registers
// Notes: times are held in units of 100 ps so that half-step values stay exact
package gap_pkg;

  // timer and counter widths
  localparam int GAP_W = 12;
  localparam int POS_W = 10;

  // register offsets
  localparam logic [7:0] ADDR_ZERO_SYNC = 8'h02;
  localparam logic [7:0] ADDR_OUT_LOGIC = 8'h1D;
  localparam logic [7:0] ADDR_ZERO_POS = 8'h1E;
  localparam logic [7:0] ADDR_GAP = 8'h1F;
  localparam logic [7:0] ADDR_DRIVER = 8'h22;
  localparam logic [7:0] ADDR_TRIM = 8'h25;
  localparam logic [7:0] ADDR_STATUS = 8'h2F;

  // reset values
  localparam logic [7:0] RST_ZERO_SYNC = 8'h00;
  localparam logic [7:0] RST_OUT_LOGIC = 8'h08;
  localparam logic [7:0] RST_ZERO_POS = 8'h00;
  localparam logic [7:0] RST_GAP = 8'h10;
  localparam logic [7:0] RST_DRIVER = 8'h00;
  localparam logic [7:0] RST_TRIM = 8'h05;

  // field positions
  localparam int ZSYNC_BIT = 4;
  localparam int ZPOS_EN_BIT = 7;
  localparam int ZPOS_MSB = 6;
  localparam int GAP_MSB = 7;
  localparam int GAP_LSB = 4;
  localparam int INV_A_BIT = 7;
  localparam int INV_B_BIT = 6;
  localparam int INV_Z_BIT = 5;
  localparam int SWAP_BIT = 4;
  localparam int TRIM_MSB = 2;
  localparam int DRV_MSB = 1;

  // alarm observation setting and position scaling
  localparam logic [9:0] ALARM_ROUTE_MASK = 10'h010;
  localparam logic [2:0] ALARM_ROUTE_HOLD = 3'h0;
  localparam logic [POS_W-1:0] BIG_FACTOR = 10'h0C8;
  localparam int POS_SCALE_SHIFT = 3;

  // drive modes
  localparam logic [1:0] DRV_PUSH_PULL = 2'h0;
  localparam logic [1:0] DRV_HIGH_SIDE = 2'h1;
  localparam logic [1:0] DRV_LOW_SIDE = 2'h2;

  // gap code limits per mode
  localparam logic [3:0] GAP_MIN_QUAD = 4'h1;
  localparam logic [3:0] GAP_MIN_COUNT = 4'h3;

  // timing base
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TIME_UNIT_PS = 100;
  localparam int PERCENT = 100;

  // edge emitter states
  typedef enum logic [2:0] {
    st_idle = 3'h1,
    st_low = 3'h2,
    st_wait = 3'h4
  } edge_state_type;

  // quadrature gap time in 100 ps units
  function automatic int gap_time(input logic [3:0] code);
    case (code)
      4'h1: gap_time = 500;
      4'h2: gap_time = 750;
      4'h3: gap_time = 1000;
      4'h4: gap_time = 1250;
      4'h5: gap_time = 1500;
      4'h6: gap_time = 1750;
      4'h7: gap_time = 2000;
      4'h8: gap_time = 3000;
      4'h9: gap_time = 4000;
      4'hA: gap_time = 6000;
      4'hB: gap_time = 8000;
      4'hC: gap_time = 10000;
      4'hD: gap_time = 12000;
      4'hE: gap_time = 14000;
      default: gap_time = 16000;
    endcase
  endfunction

  // oscillator scale in percent
  function automatic int trim_scale(input logic [2:0] code);
    case (code)
      3'h0: trim_scale = 140;
      3'h1: trim_scale = 130;
      3'h2: trim_scale = 120;
      3'h3: trim_scale = 110;
      3'h4: trim_scale = 105;
      3'h6: trim_scale = 92;
      default: trim_scale = 100;
    endcase
  endfunction

  // gap or low pulse length in clock cycles, rounded up, at least one
  function automatic logic [GAP_W-1:0] gap_cycles(input logic [3:0] code,
                                                  input logic [2:0] trim,
                                                  input logic count_mode);
    int t;
    int cyc;
    logic [3:0] c;
    c = code;
    if (count_mode && c < GAP_MIN_COUNT) begin
      c = GAP_MIN_COUNT;
    end else if (c < GAP_MIN_QUAD) begin
      c = GAP_MIN_QUAD;
    end
    t = gap_time(c);
    if (count_mode) begin
      t = t / 2;
    end
    cyc = (t * trim_scale(trim) * TIME_UNIT_PS + PERCENT * CLK_PERIOD_PS - 1)
          / (PERCENT * CLK_PERIOD_PS);
    if (cyc < 1) begin
      cyc = 1;
    end
    gap_cycles = cyc[GAP_W-1:0];
  endfunction

  // A/B levels of a quarter state: 11, 10, 00, 01
  function automatic logic [1:0] ab_of(input logic [1:0] q);
    ab_of = {~q[1], ~(q[1] ^ q[0])};
  endfunction

endpackage

// *** gap_timer_if.sv ***
// Purpose: link between the edge emitter and its gap timer
// Assumes: both ends on i_clk
// Notes: done is high while no gap is running
`timescale 1ns/1ps
interface gap_timer_if;
  import gap_pkg::*;
  logic load;
  logic [GAP_W-1:0] load_value;
  logic done;
  modport ctrl(output load, output load_value, input done);
  modport timer(input load, input load_value, output done);
endinterface

// *** gap_timer.sv ***
// Purpose: trimmed gap oscillator counter for edge spacing
// Assumes: load value already scaled by the oscillator trim
// Notes: done rises once the loaded number of cycles has elapsed
`timescale 1ns/1ps
module gap_timer
  import gap_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // timer link
  gap_timer_if.timer tif
);

  logic [GAP_W-1:0] count;
  logic [GAP_W-1:0] next_count;

  ////////////////////////////////////////////////////////////////////////////////
  // count down from the loaded gap
  always_comb begin
    next_count = count;
    if (tif.load) begin
      next_count = tif.load_value;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      count <= '0;
    end else if (i_clk_en) begin
      count <= next_count;
    end
  end

  assign tif.done = (count == '0);

  ////////////////////////////////////////////////////////////////////////////////
  // a loaded gap of more than one cycle starts from its value with done low on the next cycle
  AST_TIMER_HOLD: assert property (@(posedge i_clk) disable iff (i_reset || !i_clk_en)
    (tif.load && tif.load_value > 1) |=> !tif.done [*1] ##0 (count == $past(tif.load_value)))
    else $error("gap timer did not start from the loaded value");

endmodule

// *** quad_counter_model.sv ***
// Purpose: far-side model of a quadrature decoder or up/down counter
// Assumes: line levels are sampled on the system clock
// Notes: reports net count, shortest A/B gap and last B low length
`timescale 1ns/1ps
module quad_counter_model (
  // clock and control
  input wire logic i_clk,
  input wire logic i_clear,
  input wire logic i_counter_mode,
  // line levels
  input wire logic i_a,
  input wire logic i_b,
  // observations
  output int o_count,
  output int o_min_gap,
  output int o_low_len
);
  logic [1:0] prev;
  int run;
  int low;

  // position of an A/B level pair in the up sequence
  function automatic int pos_of(input logic [1:0] ab);
    return (ab == 2'h3) ? 0 : (ab == 2'h2) ? 1 : (ab == 2'h0) ? 2 : 3;
  endfunction

  // signed step between two levels; a skipped state counts as a large jump
  function automatic int step_of(input logic [1:0] a, input logic [1:0] b);
    int d;
    d = (pos_of(b) - pos_of(a) + 4) % 4;
    return (d == 1) ? 1 : (d == 3) ? -1 : 100;
  endfunction

  ////////////////////////////////////////
  // decode edges and time the gaps between them
  always @(posedge i_clk) begin
    if (i_clear) begin
      prev <= {i_a, i_b};
      o_count <= 0;
      o_min_gap <= 99999;
      o_low_len <= 0;
      run <= 99999;
      low <= 0;
    end else begin
      low <= i_b ? 0 : low + 1;
      run <= run + 1;
      if ({i_a, i_b} !== prev) begin
        run <= 1;
        prev <= {i_a, i_b};
        if (run < o_min_gap) begin
          o_min_gap <= run;
        end
        if (i_counter_mode && i_b && !prev[0]) begin
          o_count <= o_count + (i_a ? 1 : -1);
          o_low_len <= low;
        end else if (!i_counter_mode) begin
          o_count <= o_count + step_of(prev, {i_a, i_b});
        end
      end
    end
  end
endmodule

// *** tb.sv ***
// Purpose: self-checking bench for index gating and edge spacing
// Assumes: clock enable held high; registers reached through the register port
// Notes: random stimulus from a fixed seed; expectations from bench tables
`timescale 1ns/1ps
module tb;
  import gap_pkg::*;
  logic i_clk, i_clk_en, i_reset, i_reg_write, i_step, i_step_down, i_phase_zero;
  logic i_counter_mode, i_alarm_request, clr;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_index_pos, i_index_neg;
  logic [9:0] i_interp_factor, i_alarm_mask;
  logic [2:0] i_alarm_hold_time, o_drive_high_en, o_drive_low_en;
  logic o_channel_a_out, o_channel_b_out, o_index_out, o_alarm_out, o_alarm_oe;
  int n_fail, n_tests, count, min_gap, low_len;
  logic [1:0] abt [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
  int tt [16] = '{500, 500, 750, 1000, 1250, 1500, 1750, 2000, 3000, 4000, 6000, 8000,
                  10000, 12000, 14000, 16000};
  int kk [8] = '{140, 130, 120, 110, 105, 100, 92, 100};

  index_gating_and_edge_spacing index_gating_and_edge_spacing_inst (.i_clk(i_clk),
    .i_clk_en(i_clk_en), .i_reset(i_reset), .i_reg_write(i_reg_write),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_index_pos(i_index_pos), .i_index_neg(i_index_neg), .i_step(i_step),
    .i_step_down(i_step_down), .i_phase_zero(i_phase_zero),
    .i_interp_factor(i_interp_factor), .i_counter_mode(i_counter_mode),
    .i_alarm_mask(i_alarm_mask), .i_alarm_hold_time(i_alarm_hold_time),
    .i_alarm_request(i_alarm_request), .o_channel_a_out(o_channel_a_out),
    .o_channel_b_out(o_channel_b_out), .o_index_out(o_index_out),
    .o_drive_high_en(o_drive_high_en), .o_drive_low_en(o_drive_low_en),
    .o_alarm_out(o_alarm_out), .o_alarm_oe(o_alarm_oe));
  quad_counter_model quad_counter_model_inst (.i_clk(i_clk), .i_clear(clr),
    .i_counter_mode(i_counter_mode), .i_a(o_channel_a_out), .i_b(o_channel_b_out),
    .o_count(count), .o_min_gap(min_gap), .o_low_len(low_len));

  initial begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end

  ////////////////////////////////////////
  // expected gap or low pulse length in cycles, rounded up
  function automatic int exp_cyc(input int code, input int trim, input bit cnt);
    int t;
    t = cnt ? tt[(code < 3) ? 3 : code] / 2 : tt[code];
    return (t * kk[trim] + 4999) / 5000;
  endfunction

  // expected internal zero level
  function automatic logic exp_zero(input logic raw, input int q, input int cyc,
                                    input logic [7:0] zp, input logic [3:0] gt, input int f);
    int tg;
    tg = (f >= 200) ? zp[6:0] * 8 : zp[6:0];
    return raw & gt[3 - q] & (!zp[7] | cyc == tg);
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(negedge i_clk);
    i_reset = 1'h1;
    clr = 1'h1;
    repeat (3) @(negedge i_clk);
    i_reset = 1'h0;
    i_phase_zero = 1'h1;
    @(negedge i_clk);
    i_phase_zero = 1'h0;
    clr = 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_reg_write = 1'h1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clk);
    i_reg_write = 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    i_reg_addr = a;
    repeat (2) @(negedge i_clk);
    d = o_reg_rdata;
  endtask

  // one converter step, waiting for the far side to count it
  task automatic step(input logic down);
    int c0;
    int k;
    c0 = count;
    @(negedge i_clk);
    i_step = 1'h1;
    i_step_down = down;
    @(negedge i_clk);
    i_step = 1'h0;
    k = 0;
    while (count == c0 && k < 2000) begin
      @(negedge i_clk);
      k++;
    end
    chk("step_done", k < 2000, 1'h1);
  endtask

  ////////////////////////////////////////
  // reset values, read back and an unmapped offset
  task automatic t_regs();
    logic [7:0] d;
    logic [7:0] r;
    logic [7:0] ad [6] = '{ADDR_ZERO_SYNC, ADDR_OUT_LOGIC, ADDR_ZERO_POS, ADDR_GAP,
                           ADDR_DRIVER, ADDR_TRIM};
    logic [7:0] rv [6] = '{RST_ZERO_SYNC, RST_OUT_LOGIC, RST_ZERO_POS, RST_GAP,
                           RST_DRIVER, RST_TRIM};
    for (int i = 0; i < 6; i++) begin
      rd(ad[i], d);
      chk("reset_value", d, rv[i]);
      r = 8'($urandom);
      wr(ad[i], r);
      rd(ad[i], d);
      chk("read_back", d, r);
    end
    wr(8'h40, 8'hFF);
    rd(8'h40, d);
    chk("unmapped", d, 8'h00);
    $display("test regs done");
  endtask

  // every drive mode code, the forbidden one included; A and index inverted,
  // so the idle lines stand at index 1, B 1, A 0
  task automatic t_drive();
    wr(ADDR_OUT_LOGIC, 8'hA8);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_DRIVER, 8'(m));
      repeat (3) @(negedge i_clk);
      chk("drive_high_en", o_drive_high_en, (m < 2) ? 3'h6 : 3'h0);
      chk("drive_low_en", o_drive_low_en, (m % 2 == 0) ? 3'h1 : 3'h0);
    end
    chk("inverted", {o_index_out, o_channel_b_out, o_channel_a_out}, 3'h6);
    $display("test drive done");
  endtask

  // eight queued steps against the gap timer
  task automatic t_gap(input int code, input int trim, input bit cnt, input bit down);
    int g;
    g = exp_cyc(code, trim, cnt) + 1;
    i_counter_mode = cnt;
    do_reset();
    wr(ADDR_GAP, 8'(code << 4));
    wr(ADDR_TRIM, 8'(trim));
    for (int i = 0; i < 8; i++) begin
      step(down);
    end
    chk("count", count, down ? -8 : 8);
    if (cnt) begin
      chk("low_len", low_len, g);
      chk("direction", o_channel_a_out, !down);
    end else begin
      chk("gap_min", min_gap >= g, 1'h1);
      chk("gap_max", min_gap <= g + 2, 1'h1);
    end
    $display("test gap done");
  endtask

  // random walk of steps and index channel levels
  task automatic t_index(input int f, input bit sync);
    int q;
    int cyc;
    int r;
    logic [7:0] zp;
    logic [3:0] gt;
    logic raw;
    logic ez;
    logic route;
    logic sw;
    logic [1:0] ea;
    i_counter_mode = 1'h0;
    i_interp_factor = 10'(f);
    {i_index_pos, i_index_neg} = '0;
    do_reset();
    q = 0;
    cyc = 0;
    ez = 1'h0;
    gt = 4'($urandom);
    sw = 1'($urandom);
    zp = (f >= 200) ? 8'h81 : {1'($urandom), 7'($urandom % f)};
    wr(ADDR_OUT_LOGIC, {3'h0, sw, gt});
    wr(ADDR_ZERO_POS, zp);
    wr(ADDR_ZERO_SYNC, sync ? 8'h10 : 8'h00);
    for (int i = 0; i < 80; i++) begin
      i_index_pos = 8'($urandom);
      i_index_neg = 8'($urandom);
      raw = i_index_pos > i_index_neg;
      route = 1'($urandom);
      i_alarm_mask = route ? 10'h010 : 10'h001;
      i_alarm_hold_time = 3'($urandom % 2);
      route = route && (i_alarm_hold_time == 3'h0);
      i_alarm_request = 1'($urandom);
      r = $urandom % 8;
      repeat (3) @(negedge i_clk);
      if (r > 1) begin
        step(r == 7);
        if (r < 7) begin
          q = (q + 1) % 4;
          cyc = (q == 0) ? (cyc + 1) % f : cyc;
        end else begin
          cyc = (q == 0) ? (cyc + f - 1) % f : cyc;
          q = (q + 3) % 4;
        end
        ez = exp_zero(raw, q, cyc, zp, gt, f);
      end else if (!sync) begin
        ez = exp_zero(raw, q, cyc, zp, gt, f);
      end
      repeat (4) @(negedge i_clk);
      ea = sw ? {abt[q][0], abt[q][1]} : abt[q];
      chk("ab_state", {o_channel_a_out, o_channel_b_out}, ea);
      chk("index_out", o_index_out, ez);
      chk("alarm_oe", o_alarm_oe, route ? !raw : i_alarm_request);
      chk("alarm_out", o_alarm_out, 1'h0);
    end
    $display("test index done");
  endtask

  ////////////////////////////////////////
  initial begin
    {i_reg_write, i_step, i_step_down, i_phase_zero, i_counter_mode} = '0;
    {i_reg_addr, i_reg_wdata, i_index_pos, i_index_neg} = '0;
    {i_alarm_mask, i_alarm_hold_time, i_alarm_request} = '0;
    i_interp_factor = 10'h004;
    i_clk_en = 1'h1;
    i_reset = 1'h1;
    clr = 1'h1;
    n_fail = 0;
    n_tests = 0;
    void'($urandom(32'h19BE));
    repeat (3) @(negedge i_clk);
    i_reset = 1'h0;
    t_regs();
    t_drive();
    t_gap(0, 5, 0, 0);
    t_gap(1, 6, 1, 1);
    t_gap(15, 0, 1, 0);
    repeat (5) t_gap($urandom % 16, $urandom % 8, $urandom % 2, $urandom % 2);
    t_index(3, 0);
    t_index(200, 0);
    t_index(3, 1);
    conclude();
  end

  // watchdog well beyond the expected run time
  initial begin
    #300000;
    n_fail++;
    conclude();
  end
endmodule
